// >>> adc_regs_pkg.sv
// package: register map, field layout and mode codes of the converter registers
package adc_regs_pkg;

  // word offsets on the wishbone bus (byte addresses)
  localparam logic [7:0] OFF_RESULT_HIGH  = 8'h00;
  localparam logic [7:0] OFF_RESULT_LOW   = 8'h04;
  localparam logic [7:0] OFF_CMP_HIGH     = 8'h08;
  localparam logic [7:0] OFF_CMP_LOW      = 8'h0c;
  localparam logic [7:0] OFF_CONFIG       = 8'h10;
  localparam logic [7:0] OFF_PIN_CTL      = 8'h14;
  localparam logic [7:0] OFF_STATUS_CTL   = 8'h18;

  // reset values
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [1:0] RST_SC1          = 2'h0;

  // configuration field positions
  localparam int CFG_LOW_POWER_BIT        = 7;
  localparam int CFG_DIV_HI               = 6;
  localparam int CFG_DIV_LO               = 5;
  localparam int CFG_LONG_SAMPLE_BIT      = 4;
  localparam int CFG_MODE_HI              = 3;
  localparam int CFG_MODE_LO              = 2;
  localparam int CFG_CLK_HI               = 1;
  localparam int CFG_CLK_LO               = 0;

  // status/control field positions (own register)
  localparam int SC_CONVERSION_COMPLETE_FLAG_BIT              = 7;
  localparam int SC_CMP_EN_BIT            = 5;
  localparam int SC_CMP_GT_BIT            = 4;

  // conversion mode encodings
  localparam logic [1:0] MODE_8BIT        = 2'h0;
  localparam logic [1:0] MODE_12BIT       = 2'h1;
  localparam logic [1:0] MODE_10BIT       = 2'h2;

  // clock source encodings
  localparam logic [1:0] CLK_BUS          = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF     = 2'h1;
  localparam logic [1:0] CLK_ALT          = 2'h2;
  localparam logic [1:0] CLK_ASYNC        = 2'h3;

  localparam int RES_W                    = 12;
  localparam logic [3:0] ZERO_NIB         = 4'h0;

endpackage

// >>> adc_cmp_unit.sv
// compare unit: mode-masked compare and difference of result and compare value
`timescale 1ns/1ns
module adc_cmp_unit
  import adc_regs_pkg::*;
(
  input  wire logic [11:0] result_i,
  input  wire logic [11:0] compare_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        greater_i,
  output logic             hit_o,
  output logic [11:0]      diff_o
);

  logic [11:0] res_m;
  logic [11:0] cmp_m;

  // mask both operands to the active width before comparing
  always_comb begin
    res_m = result_i;
    cmp_m = compare_i;
    // reserved mode compares at full width, like the result path
    case (mode_i)
      MODE_8BIT: begin
        res_m = {4'h0, result_i[7:0]};
        cmp_m = {4'h0, compare_i[7:0]};
      end
      MODE_10BIT: begin
        res_m = {2'h0, result_i[9:0]};
        cmp_m = {2'h0, compare_i[9:0]};
      end
      default: begin
        cmp_m = compare_i;
      end
    endcase
  end

  // less-than by default, greater-or-equal when selected
  assign hit_o  = greater_i ? (res_m >= cmp_m) : (res_m < cmp_m);
  // difference: result plus two's complement of compare value
  assign diff_o = res_m + (~cmp_m + 12'h001);

endmodule

// >>> adc_result_compare_config_regs.sv
// result, compare and configuration registers of the approximation converter
//
// Function
// - 12-bit: top four bits in result_high
// - 10-bit: two high bits, bits 11:10 zero
// - 8-bit: bits 11:8 zero, all in low
// - load on completion unless compare fails
// - compare event stores result minus compare
// - high read locks transfers until low read
// - completions during lock are dropped
// - 8-bit mode has no read lock
// - results undefined after mode change
// - 12-bit compares high four compare bits
// - 10-bit compares compare bits 9:8
// - 8-bit ignores compare_value_high
// - compare_value_low compared in every mode
// - config bit 7 selects low power
// - config bits 6:5 set clock divide
// - config bit 4 selects long sample
// - config bits 3:2 set resolution
// - config bits 1:0 select clock source
// - pin bit n disables port on ch n
// - disabled pin: hi-z, no input, no pullup
// - complete flag cleared by low read, sc1 write
// - compare less-than or greater-or-equal select
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module adc_result_compare_config_regs
  import adc_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // converter core, same clock
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_result_i,
  output logic             low_power_select_o,
  output logic [1:0]       clock_divide_select_o,
  output logic             long_sample_select_o,
  output logic [1:0]       mode_o,
  output logic [1:0]       clock_source_select_o,
  output logic             conversion_complete_flag_o,
  // pin side, channels 0-7
  input  wire logic [7:0]  port_out_i,
  input  wire logic [7:0]  port_oe_i,
  input  wire logic [7:0]  port_pullup_i,
  input  wire logic [7:0]  pad_in_i,
  output logic [7:0]       pad_out_o,
  output logic [7:0]       pad_oe_o,
  output logic [7:0]       pad_pullup_o,
  output logic [7:0]       port_in_o
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  //
  // all state sits on the bus clock; the converter core hands its result
  // over on the same clock, so no synchroniser is needed on that path.
  // only the pad inputs come from outside and pass two flops first.
  //
  // the read lock is a single bit rather than a shadow copy of the result:
  // a completion that arrives while it is held is simply dropped, which
  // keeps the high and low bytes of one result together for software at
  // the cost of losing the intermediate conversion.
  //
  // the compare value is kept as two bytes exactly as written; masking to
  // the active width happens in the compare unit, so a mode change takes
  // effect on the next completion without rewriting the compare bytes.
  //
  // ce_i low freezes every flop here, including the bus answer, so a
  // master must not expect an ack while the enable is held low.

  logic [7:0]  result_high_q;
  logic [7:0]  result_low_q;
  logic [7:0]  compare_value_high_q;
  logic [7:0]  compare_value_low_q;
  logic [7:0]  converter_configuration_q;
  logic [7:0]  pin_control_ch0_7_q;
  logic        compare_enable_q;
  logic        compare_greater_select_q;
  logic        conversion_complete_flag_q;
  logic        read_lock_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] dat_q;
  logic [7:0]  pad_sync1_q;
  logic [7:0]  pad_sync2_q;

  logic        bus_req;
  logic        wr_lane0;
  logic        rd_req;
  logic        mapped;
  logic        read_high;
  logic        read_low;
  logic        write_sc1;
  logic [1:0]  mode;
  logic        cmp_hit;
  logic [11:0] cmp_diff;
  logic [11:0] load_val;
  logic        transfer;
  logic [7:0]  rd_byte;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  // new request only when no ack is pending, giving one-cycle ack then drop
  assign bus_req  = cyc_i & stb_i & ~ack_q & ~err_q;
  assign wr_lane0 = bus_req & we_i & sel_i[0];
  assign rd_req   = bus_req & ~we_i;

  // address recognised by this block
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_RESULT_HIGH) | (a == OFF_RESULT_LOW) |
                (a == OFF_CMP_HIGH)    | (a == OFF_CMP_LOW)    |
                (a == OFF_CONFIG)      | (a == OFF_PIN_CTL)    |
                (a == OFF_STATUS_CTL);
  endfunction

  assign mapped    = is_mapped(adr_i);
  assign read_high = rd_req & (adr_i == OFF_RESULT_HIGH);
  assign read_low  = rd_req & (adr_i == OFF_RESULT_LOW);
  // any lane write to the status/control word counts as a write to it
  assign write_sc1 = bus_req & we_i & (adr_i == OFF_STATUS_CTL) & (|sel_i);

  //////////////////////////////////////////////////////////////////////////////
  // configuration fields

  assign mode                  = converter_configuration_q[CFG_MODE_HI:CFG_MODE_LO];
  assign low_power_select_o    = converter_configuration_q[CFG_LOW_POWER_BIT];
  assign clock_divide_select_o = converter_configuration_q[CFG_DIV_HI:CFG_DIV_LO];
  assign long_sample_select_o  = converter_configuration_q[CFG_LONG_SAMPLE_BIT];
  assign mode_o                = mode;
  assign clock_source_select_o = converter_configuration_q[CFG_CLK_HI:CFG_CLK_LO];
  assign conversion_complete_flag_o = conversion_complete_flag_q;

  //////////////////////////////////////////////////////////////////////////////
  // compare and result transfer

  adc_cmp_unit u_cmp (
    .result_i  (conv_result_i),
    .compare_i ({compare_value_high_q[3:0], compare_value_low_q}),
    .mode_i    (mode),
    .greater_i (compare_greater_select_q),
    .hit_o     (cmp_hit),
    .diff_o    (cmp_diff)
  );

  // on a compare event store the difference, else the plain result
  assign load_val = compare_enable_q ? cmp_diff : conv_result_i;

  // lock applies in every mode but 8-bit, reserved included; 8-bit is never held back by it
  assign transfer = conv_done_i & (~compare_enable_q | cmp_hit)
                  & ~(read_lock_q & (mode != MODE_8BIT));

  // result registers: width-aligned per mode; reserved mode treated as 12-bit
  // a mode change leaves old contents, which software must not trust
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_high_q <= RST_BYTE;
      result_low_q  <= RST_BYTE;
    end else if (ce_i && transfer) begin
      result_low_q <= load_val[7:0];
      case (mode)
        MODE_8BIT: begin
          result_high_q <= {ZERO_NIB, ZERO_NIB};
        end
        MODE_10BIT: begin
          result_high_q <= {ZERO_NIB, 2'h0, load_val[9:8]};
        end
        default: begin
          result_high_q <= {ZERO_NIB, load_val[11:8]};
        end
      endcase
    end
  end

  // read lock: set by high read in any mode but 8-bit, reserved included, released by low read or 8-bit mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_lock_q <= 1'b0;
    end else if (ce_i) begin
      if (read_low || mode == MODE_8BIT) begin
        read_lock_q <= 1'b0;
      end else if (read_high) begin
        read_lock_q <= 1'b1;
      end
    end
  end

  // complete flag: a new result wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_complete_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (transfer) begin
        conversion_complete_flag_q <= 1'b1;
      end else if (read_low || write_sc1) begin
        conversion_complete_flag_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software-written registers

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_high_q      <= RST_BYTE;
      compare_value_low_q       <= RST_BYTE;
      converter_configuration_q <= RST_BYTE;
      pin_control_ch0_7_q       <= RST_BYTE;
      compare_enable_q          <= 1'b0;
      compare_greater_select_q  <= 1'b0;
    end else if (ce_i && wr_lane0) begin
      case (adr_i)
        OFF_CMP_HIGH:   compare_value_high_q      <= dat_i[7:0];
        OFF_CMP_LOW:    compare_value_low_q       <= dat_i[7:0];
        OFF_CONFIG:     converter_configuration_q <= dat_i[7:0];
        OFF_PIN_CTL:    pin_control_ch0_7_q       <= dat_i[7:0];
        OFF_STATUS_CTL: begin
          compare_enable_q         <= dat_i[SC_CMP_EN_BIT];
          compare_greater_select_q <= dat_i[SC_CMP_GT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus answer

  // read mux of the addressed byte
  always_comb begin
    case (adr_i)
      OFF_RESULT_HIGH: rd_byte = result_high_q;
      OFF_RESULT_LOW:  rd_byte = result_low_q;
      OFF_CMP_HIGH:    rd_byte = compare_value_high_q;
      OFF_CMP_LOW:     rd_byte = compare_value_low_q;
      OFF_CONFIG:      rd_byte = converter_configuration_q;
      OFF_PIN_CTL:     rd_byte = pin_control_ch0_7_q;
      OFF_STATUS_CTL:  rd_byte = {conversion_complete_flag_q, 1'b0,
                                  compare_enable_q, compare_greater_select_q,
                                  ZERO_NIB};
      default:         rd_byte = RST_BYTE;
    endcase
  end

  // ack or err one cycle after the request, dropped the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= bus_req & mapped;
      err_q <= bus_req & ~mapped;
      if (rd_req) begin
        dat_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;
  assign dat_o = dat_q;

  //////////////////////////////////////////////////////////////////////////////
  // pin control, channels 0-7

  // pad inputs are asynchronous, so two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_sync1_q <= RST_BYTE;
      pad_sync2_q <= RST_BYTE;
    end else if (ce_i) begin
      pad_sync1_q <= pad_in_i;
      pad_sync2_q <= pad_sync1_q;
    end
  end

  // set bit hands the pin to the analog side: hi-z, no pullup, reads zero
  assign pad_out_o    = port_out_i & ~pin_control_ch0_7_q;
  assign pad_oe_o     = port_oe_i & ~pin_control_ch0_7_q;
  assign pad_pullup_o = port_pullup_i & ~pin_control_ch0_7_q;
  assign port_in_o    = pad_sync2_q & ~pin_control_ch0_7_q;

endmodule

// >>> adc_regs_properties.sv
// checker: bus answer, flag and pin gating properties of the register block
`timescale 1ns/1ns
module adc_regs_properties
  import adc_regs_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic [7:0] adr_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  input wire logic       conv_done_i,
  input wire logic [1:0] mode_o,
  input wire logic [1:0] clock_source_select_o,
  input wire logic       conversion_complete_flag_o,
  input wire logic [7:0] port_oe_i,
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] port_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic fl;
  // a request is taken only while no answer is standing
  assign take = cyc_i && stb_i && ce_i && !ack_o && !err_o;
  assign fl = conversion_complete_flag_o;
  //////////////////////////////////////////////////////////////////////////
  // bus answers
  answer_next_a: assert property (take |=> ack_o ^ err_o)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  unmapped_err_a: assert property (take && adr_i > OFF_STATUS_CTL |=> err_o)
    else $error("unmapped address not refused");
  mapped_ack_a: assert property (
    take && adr_i <= OFF_STATUS_CTL && adr_i[1:0] == 2'h0 |=> ack_o)
    else $error("mapped address not acknowledged");
  //////////////////////////////////////////////////////////////////////////
  // flag and configuration only move for their causes
  flag_set_a: assert property ($rose(fl) |-> $past(conv_done_i))
    else $error("flag set without a completion");
  flag_clear_a: assert property (
    $fell(fl) |-> ack_o && (adr_i == OFF_RESULT_LOW && !we_i
                            || adr_i == OFF_STATUS_CTL && we_i))
    else $error("flag cleared without low read or control write");
  config_cause_a: assert property (
    $changed({mode_o, clock_source_select_o})
      |-> ack_o && we_i && adr_i == OFF_CONFIG)
    else $error("configuration changed without a write");
  //////////////////////////////////////////////////////////////////////////
  // pin gating can only remove drive and input, never add it
  pad_oe_gate_a: assert property ((pad_oe_o & ~port_oe_i) == 8'h00)
    else $error("pad driven without port enable");
  port_in_gate_a: assert property (
    (port_in_o & ~$past(pad_in_i, 2)) == 8'h00)
    else $error("port input high without pad level");
  cover property (take && adr_i == OFF_RESULT_HIGH && !we_i);
  cover property ($rose(fl));
  cover property (err_o);
endmodule

bind adc_result_compare_config_regs adc_regs_properties adc_regs_properties_i (
  .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .ack_o, .err_o,
  .conv_done_i, .mode_o, .clock_source_select_o,
  .conversion_complete_flag_o, .port_oe_i, .pad_in_i, .pad_oe_o, .port_in_o
);

// >>> adc_core_model.sv
// partner model: converter core that completes after a chosen delay
`timescale 1ns/1ns
module adc_core_model (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  delay_i,
  input  wire logic [11:0] value_i,
  output logic             conv_done_o = 1'h0,
  output logic [11:0]      conv_result_o = 12'h000
);
  logic        busy_q = 1'h0;
  logic [4:0]  cnt_q = 5'h00;
  logic [11:0] val_q = 12'h000;
  // result is valid only with the done pulse; otherwise the lines toggle
  // every cycle so a late sample in the block shows up as a wrong value
  always_ff @(posedge clk_i) begin
    conv_done_o <= 1'h0;
    conv_result_o <= ~conv_result_o;
    if (start_i) begin
      busy_q <= 1'h1;
      cnt_q <= delay_i;
      val_q <= value_i;
    end else if (busy_q && cnt_q == 5'h00) begin
      busy_q <= 1'h0;
      conv_done_o <= 1'h1;
      conv_result_o <= val_q;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// >>> adc_result_compare_config_regs_tb.sv
// testbench: bus access, conversions, compare and pin gating
`timescale 1ns/1ns
module adc_result_compare_config_regs_tb;
  import adc_regs_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
  logic        cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, err_o, conv_done_i, flag, got_err;
  logic        low_power_select_o, long_sample_select_o, start = 1'h0;
  logic [1:0]  clock_divide_select_o, mode_o, clock_source_select_o;
  logic [11:0] conv_result_i, val = 12'h000;
  logic [4:0]  dly = 5'h00;
  logic [7:0]  lvl = 8'hff, rd_q, cfg;
  logic [7:0]  pad_out_o, pad_oe_o, pad_pullup_o, port_in_o;
  logic [1:0]  mk [3] = '{MODE_12BIT, MODE_10BIT, MODE_8BIT};
  logic [7:0]  hx [3] = '{8'h0a, 8'h02, 8'h00};
  int          n_errors = 0, compares = 0;

  adc_result_compare_config_regs adc_result_compare_config_regs_i (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .conv_done_i, .conv_result_i,
    .low_power_select_o, .clock_divide_select_o, .long_sample_select_o,
    .mode_o, .clock_source_select_o, .conversion_complete_flag_o(flag),
    .port_out_i(lvl), .port_oe_i(lvl), .port_pullup_i(lvl), .pad_in_i(lvl),
    .pad_out_o, .pad_oe_o, .pad_pullup_o, .port_in_o
  );
  adc_core_model adc_core_model_i (
    .clk_i, .start_i(start), .delay_i(dly), .value_i(val),
    .conv_done_o(conv_done_i), .conv_result_o(conv_result_i)
  );
  // free running bus clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack or err is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'h3, w, a, 4'h1};
    dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
    rd_q = dat_o[7:0];
    got_err = err_o;
    {cyc_i, stb_i, sel_i} <= 6'h00;
    if (n >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'h0, a, 8'h00);
    chk(rd_q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  // odd values use a slow core, even ones a prompt one
  task automatic conv(input logic [11:0] v);
    int n;
    @(posedge clk_i);
    {start, val, dly} <= {1'h1, v, v[0] ? 5'h09 : 5'h00};
    @(posedge clk_i);
    start <= 1'h0;
    n = 0;
    while (conv_done_i !== 1'h1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    if (n >= 40) begin
      n_errors++;
      complete_run();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int a = 0; a < 28; a += 4) rd(a[7:0], 8'h00);
    bus(1'h0, 8'h1c, 8'h00);
    chk({7'h0, got_err}, 8'h01);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      cfg = {i[0], i[1:0], i[1], i[1:0], i[1:0]};
      wr(OFF_CONFIG, cfg);
      chk({low_power_select_o, clock_divide_select_o, long_sample_select_o,
           mode_o, clock_source_select_o}, cfg);
      rd(OFF_CONFIG, cfg);
    end
    wr(OFF_PIN_CTL, 8'ha5);
    repeat (3) @(posedge clk_i);
    chk(pad_oe_o, 8'h5a);
    chk(pad_out_o, 8'h5a);
    chk(pad_pullup_o, 8'h5a);
    chk(port_in_o, 8'h5a);
    $display("test configuration and pins done");
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CONFIG, {4'h0, mk[m], 2'h0});
      conv(12'habc);
      chk({7'h0, flag}, 8'h01);
      rd(OFF_RESULT_HIGH, hx[m]);
      rd(OFF_RESULT_LOW, 8'hbc);
      chk({7'h0, flag}, 8'h00);
    end
    conv(12'h045);
    rd(OFF_RESULT_HIGH, 8'h00);
    conv(12'h067);
    rd(OFF_RESULT_LOW, 8'h67);
    wr(OFF_CONFIG, {4'h0, MODE_12BIT, 2'h0});
    conv(12'h123);
    rd(OFF_RESULT_HIGH, 8'h01);
    conv(12'h456);
    rd(OFF_RESULT_LOW, 8'h23);
    conv(12'h789);
    rd(OFF_RESULT_HIGH, 8'h07);
    rd(OFF_RESULT_LOW, 8'h89);
    $display("test alignment and interlock done");
    wr(OFF_CMP_HIGH, 8'h01);
    wr(OFF_CMP_LOW, 8'h00);
    wr(OFF_STATUS_CTL, 8'h20);
    conv(12'h0ff);
    chk({7'h0, flag}, 8'h01);
    rd(OFF_RESULT_HIGH, 8'h0f);
    rd(OFF_RESULT_LOW, 8'hff);
    conv(12'h200);
    chk({7'h0, flag}, 8'h00);
    rd(OFF_RESULT_LOW, 8'hff);
    wr(OFF_STATUS_CTL, 8'h30);
    conv(12'h300);
    rd(OFF_RESULT_HIGH, 8'h02);
    rd(OFF_RESULT_LOW, 8'h00);
    wr(OFF_STATUS_CTL, 8'h30);
    chk({7'h0, flag}, 8'h00);
    wr(OFF_CONFIG, {4'h0, MODE_10BIT, 2'h0});
    wr(OFF_CMP_HIGH, 8'h07);
    conv(12'h3ff);
    rd(OFF_RESULT_HIGH, 8'h00);
    rd(OFF_RESULT_LOW, 8'hff);
    wr(OFF_CONFIG, {4'h0, MODE_8BIT, 2'h0});
    wr(OFF_CMP_LOW, 8'h10);
    conv(12'h020);
    rd(OFF_RESULT_LOW, 8'h10);
    $display("test compare done");
    complete_run();
  end
endmodule
